/* File: inc/dbm_pkg.sv */
// Package for the boot mode and axis select block.
// Assumes a 10 MHz system clock and a classic 32-bit Wishbone slave port.
package dbm_pkg;

  // Clock and power-on window
  localparam int CLK_HZ        = 10_000_000;
  localparam int INIT_TIME_MS  = 1000;
  localparam int INIT_CYCLES   = INIT_TIME_MS * (CLK_HZ / 1000);

  // Register byte offsets
  localparam logic [7:0] REG_NV_WORD = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_LSS_ID  = 8'h08;

  // Values
  localparam logic [15:0] NV_WORD_RST   = 16'h0000;
  localparam logic [15:0] NV_NO_LAUNCH  = 16'h0001;
  localparam logic [7:0]  ID_FALLBACK   = 8'hFF;
  localparam logic [7:0]  ID_NONE       = 8'h00;
  localparam logic [7:0]  LSS_ID_MAX    = 8'h7F;
  localparam logic [3:0]  ROT_ZERO      = 4'h0;

  // Status field positions
  localparam int ST_CANOPEN = 8;
  localparam int ST_UNCONF  = 9;
  localparam int ST_SLAVE   = 10;
  localparam int ST_READY   = 11;
  localparam int ST_RUN     = 12;
  localparam int ST_CAN_EN  = 13;

  // Switch inputs travel together
  typedef struct packed {
    logic       canopen;   // Dip position 6, high when ON
    logic [3:0] rotary;    // Hex rotary position
  } dbm_switch_t;

  typedef enum logic [1:0] {
    DBM_SAMPLE = 2'b00,
    DBM_WAIT   = 2'b01,
    DBM_READY  = 2'b10
  } dbm_state_t;

endpackage : dbm_pkg

/* File: logic/dbm_boot_select.sv */
// Power-on boot mode, CAN protocol and axis identifier selection.
// Assumes switches and hall pins are synchronous and debounced upstream.
//
// Chosen here: register access over Wishbone and the register offsets.
`timescale 1ns/10ps

module dbm_boot_select
  import dbm_pkg::*;
#(
  parameter int INIT_LEN = dbm_pkg::INIT_CYCLES
)(
  input  wire logic              clk,            // 10 MHz clock
  input  wire logic              srst,           // Sync reset, high
  input  wire logic              wb_cyc_i,       // Bus cycle
  input  wire logic              wb_stb_i,       // Bus strobe
  input  wire logic              wb_we_i,        // Write enable
  input  wire logic [7:0]        wb_adr_i,       // Byte address
  input  wire logic [3:0]        wb_sel_i,       // Byte lanes
  input  wire logic [31:0]       wb_dat_i,       // Write data
  output logic      [31:0]       wb_dat_o,       // Read data
  output logic                   wb_ack_o,       // Acknowledge
  input  dbm_pkg::dbm_switch_t   switch_in,      // Dip and rotary
  input  wire logic [2:0]        hall_in,        // Digital halls
  input  wire logic              prog_stored,    // Program in memory
  input  wire logic [15:0]       nv_word_in,     // Saved first word
  input  wire logic [7:0]        nv_lss_id_in,   // Saved id, 0 none
  input  wire logic              motor_supply,   // Motor supply on
  input  wire logic              error_in,       // Drive error
  output logic                   ready_led,      // Ready indicator
  output logic                   can_open_mode,  // CANopen selected
  output logic [7:0]             can_axis_id,    // Active CAN id
  output logic                   can_id_valid,   // CAN exchange allowed
  output logic [7:0]             serial_axis_id, // Serial link id
  output logic                   program_run,    // Launch program
  output logic                   slave_mode,     // Not launching
  output logic [15:0]            nv_word_out,    // Word to persist
  output logic                   lss_store,      // Persist id pulse
  output logic [7:0]             lss_store_id    // Id to persist
);
  import dbm_pkg::*;

  localparam int CW = $clog2(INIT_LEN + 1);

  initial
  begin
    if (INIT_LEN < 2)
      $error("INIT_LEN must be at least 2");
  end

  function automatic logic [7:0] map_id(input logic [3:0] pos);
    map_id = (pos == ROT_ZERO) ? ID_FALLBACK : {4'h0, pos};
  endfunction : map_id

  //////////////////////////////////////////////////////////////////////////
  // Power-on sequencing

  dbm_state_t  state_reg, state_next;
  logic [CW-1:0] cnt_reg;
  dbm_switch_t sw_reg;
  logic        hall_low_reg;
  logic        prog_reg;
  logic        unconf_reg;
  logic [7:0]  lss_id_reg;
  logic [15:0] nv_reg;
  logic        ready_reg;
  logic        run_reg;
  logic        ack_reg;
  logic [31:0] rdat_reg;
  logic        store_reg;

  wire in_sample  = (state_reg == DBM_SAMPLE);
  wire in_wait    = (state_reg == DBM_WAIT);
  wire in_ready   = (state_reg == DBM_READY);
  wire halls_low  = (hall_in == 3'h0);
  wire cnt_done   = (cnt_reg == CW'(INIT_LEN - 1));

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      DBM_SAMPLE: state_next = DBM_WAIT;
      DBM_WAIT:   if (cnt_done) state_next = DBM_READY;
      DBM_READY:  state_next = DBM_READY;
      default:    state_next = DBM_SAMPLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      state_reg <= DBM_SAMPLE;
    else
      state_reg <= state_next;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      cnt_reg <= '0;
    else if (in_wait && !cnt_done)
      cnt_reg <= cnt_reg + CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      sw_reg <= '0;
    else if (in_sample)
      sw_reg <= switch_in;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      prog_reg <= 1'b0;
    else if (in_sample)
      prog_reg <= prog_stored;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      hall_low_reg <= 1'b1;
    else if (!in_ready)
      hall_low_reg <= hall_low_reg & halls_low;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus decode

  wire bus_req  = wb_cyc_i & wb_stb_i;
  wire wr_take  = bus_req & ack_reg & wb_we_i;
  wire sel_nv   = (wb_adr_i == REG_NV_WORD);
  wire sel_st   = (wb_adr_i == REG_STATUS);
  wire sel_lss  = (wb_adr_i == REG_LSS_ID);
  wire wr_nv    = wr_take & sel_nv;
  wire wr_lss   = wr_take & sel_lss & wb_sel_i[0];
  wire [7:0] lss_new = wb_dat_i[7:0];
  wire lss_ok   = (lss_new != ID_NONE) && (lss_new <= LSS_ID_MAX);
  wire lss_take = wr_lss & unconf_reg & in_ready & lss_ok;

  wire [15:0] nv_merge = {wb_sel_i[1] ? wb_dat_i[15:8] : nv_reg[15:8],
                          wb_sel_i[0] ? wb_dat_i[7:0]  : nv_reg[7:0]};

  always_ff @(posedge clk)
  begin
    if (srst)
      nv_reg <= NV_WORD_RST;
    else if (in_sample)
      nv_reg <= nv_word_in;
    else if (wr_nv)
      nv_reg <= nv_merge;
  end

  //////////////////////////////////////////////////////////////////////////
  // Mode and identifier

  wire canopen   = sw_reg.canopen;
  wire rot_zero  = (sw_reg.rotary == ROT_ZERO);
  wire saved_ok  = (lss_id_reg != ID_NONE);

  always_ff @(posedge clk)
  begin
    if (srst)
      unconf_reg <= 1'b0;
    else if (in_wait && cnt_done)
      unconf_reg <= canopen & rot_zero & !saved_ok;
    else if (lss_take)
      unconf_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      lss_id_reg <= ID_NONE;
    else if (in_sample)
      lss_id_reg <= nv_lss_id_in;
    else if (lss_take)
      lss_id_reg <= lss_new;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      store_reg <= 1'b0;
    else
      store_reg <= lss_take;
  end

  wire [7:0] id_active = (canopen && rot_zero) ? lss_id_reg
                                               : map_id(sw_reg.rotary);

  //////////////////////////////////////////////////////////////////////////
  // Launch decision

  wire prog_valid = prog_reg & (nv_reg != NV_NO_LAUNCH);
  wire launch_ok  = !canopen & prog_valid & !hall_low_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
      run_reg <= 1'b0;
    else
      run_reg <= in_ready & launch_ok & motor_supply;
  end

  // Ready after init, off on error
  always_ff @(posedge clk)
  begin
    if (srst)
      ready_reg <= 1'b0;
    else
      ready_reg <= (in_ready | (in_wait & cnt_done)) & !error_in;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus answer

  wire [31:0] status_word = {18'h0, can_id_valid, run_reg, ready_reg,
                             !launch_ok, unconf_reg, canopen, can_axis_id};

  wire [31:0] rd_mux = sel_nv  ? {16'h0, nv_reg} :
                       sel_st  ? status_word :
                       sel_lss ? {24'h0, lss_id_reg} : 32'h0;

  always_ff @(posedge clk)
  begin
    if (srst)
      ack_reg <= 1'b0;
    else
      ack_reg <= bus_req & !ack_reg;
  end

  always_ff @(posedge clk)
  begin
    if (srst)
      rdat_reg <= 32'h0;
    else if (bus_req & !ack_reg)
      rdat_reg <= rd_mux;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o       = ack_reg;
  assign wb_dat_o       = rdat_reg;
  assign ready_led      = ready_reg;
  assign can_open_mode  = canopen;
  assign can_id_valid   = in_ready & !unconf_reg;
  assign can_axis_id    = unconf_reg ? ID_NONE : id_active;
  assign serial_axis_id = unconf_reg ? ID_FALLBACK : id_active;
  assign program_run    = run_reg;
  assign slave_mode     = !launch_ok;
  assign nv_word_out    = nv_reg;
  assign lss_store      = store_reg;
  assign lss_store_id   = lss_id_reg;

  //////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence lss_write_s;
    lss_take;
  endsequence

  sequence lss_done_s;
    lss_store && !unconf_reg && lss_store_id == $past(lss_new);
  endsequence

  ready_window_a: assert property (
    in_wait && cnt_done && !error_in |=> ready_led)
    else $error("ready not lit after init window");

  ready_error_a: assert property (
    error_in |=> !ready_led)
    else $error("ready lit during error");

  canopen_norun_a: assert property (
    can_open_mode |-> !program_run)
    else $error("program launched in CANopen mode");

  auto_launch_a: assert property (
    in_ready && launch_ok && motor_supply |=> program_run)
    else $error("valid program did not launch");

  nv_block_a: assert property (
    program_run |-> $past(nv_reg) != NV_NO_LAUNCH && prog_reg)
    else $error("launched with invalid program");

  hall_slave_a: assert property (
    hall_low_reg && in_ready |-> slave_mode && !program_run)
    else $error("launched despite hall slave strap");

  native_zero_a: assert property (
    in_ready && !canopen && rot_zero |-> can_axis_id == 8'hFF)
    else $error("native zero position id wrong");

  unconf_silent_a: assert property (
    unconf_reg |-> !can_id_valid && serial_axis_id == 8'hFF)
    else $error("unconfigured node on CAN");

  lss_store_a: assert property (
    lss_write_s |=> lss_done_s)
    else $error("assigned id not stored");

  switch_hold_a: assert property (
    in_ready && $past(in_ready) |-> $stable(sw_reg))
    else $error("switch capture changed after init");

  bus_ack_a: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

endmodule : dbm_boot_select

/* File: testbench/dbm_nv_model.sv */
// Nonvolatile store standing behind the block for the layer-setting id.
// Assumes one clock; contents survive every reset of the block.
`timescale 1ns/10ps
module dbm_nv_model
(
  input  wire logic       clk,       // System clock
  input  wire logic       lss_store, // Persist pulse
  input  wire logic [7:0] store_id,  // Id to persist
  output logic      [7:0] saved_id   // Id read at init
);
  initial saved_id = 8'h00;
  always @(posedge clk)
  begin
    if (lss_store)
    begin
      saved_id <= store_id;
    end
  end
endmodule : dbm_nv_model

/* File: testbench/drive_boot_mode_axis_select_test.sv */
// Self-checking bench for the boot mode and axis select block.
// Assumes the 1-cycle Wishbone answer and a short init window.
`timescale 1ns/10ps
module drive_boot_mode_axis_select_test;
  import dbm_pkg::*;
  localparam int LEN = 8;
  logic        clk = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0;
  logic        we = 1'b0, err = 1'b0, sup = 1'b1, prog = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0, rd, dat_o;
  logic [15:0] word = 16'h0000, nvw;
  logic [2:0]  hall = 3'h7;
  dbm_switch_t sw = '0;
  logic        ack, led, copen, idv, run, slv, lst;
  logic [7:0]  cid, sid, lid, nvid;
  int          fail_count = 0, n_compared = 0, cyc_n = 0;
  always #50 clk = ~clk;
  dbm_boot_select #(.INIT_LEN(LEN)) i_dbm_boot_select (.clk(clk),
    .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack), .switch_in(sw), .hall_in(hall), .prog_stored(prog),
    .nv_word_in(word), .nv_lss_id_in(nvid), .motor_supply(sup),
    .error_in(err), .ready_led(led), .can_open_mode(copen),
    .can_axis_id(cid), .can_id_valid(idv), .serial_axis_id(sid),
    .program_run(run), .slave_mode(slv), .nv_word_out(nvw),
    .lss_store(lst), .lss_store_id(lid));
  dbm_nv_model i_dbm_nv_model (.clk(clk), .lss_store(lst),
    .store_id(lid), .saved_id(nvid));
  //////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("compared=%0d mismatched=%0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Single classic cycle, held until ack is seen
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic power_on(input logic co, input logic [3:0] r,
                          input logic [2:0] h, input logic p);
    @(posedge clk);
    srst <= 1'b1;
    sw <= {co, r};
    hall <= h;
    prog <= p;
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    repeat (LEN + 6) @(posedge clk);
    @(negedge clk);
  endtask : power_on
  always @(posedge clk)
  begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 4000)
    begin
      fail_count++;
      final_report();
    end
  end
  //////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int r = 0; r < 16; r++)
    begin
      power_on(1'b0, 4'(r), 3'h5, 1'b1);
      check(32'(cid), (r == 0) ? 32'hFF : 32'(r));
      check(32'(sid), (r == 0) ? 32'hFF : 32'(r));
      check(32'({run, led, copen, idv}), 32'hD);
    end
    $display("native ids done");
    @(posedge clk);
    sw <= {1'b1, 4'h3};
    sup <= 1'b0;
    repeat (3) @(negedge clk);
    check(32'(cid), 32'h0F);
    check(32'(run), 32'h0);
    @(posedge clk);
    sup <= 1'b1;
    wb(1'b1, 8'h04, 32'hFFFFFFFF);
    wb(1'b0, 8'h04, 32'h0);
    check(rd, 32'h0000380F);
    wb(1'b1, 8'h00, 32'h00000001);
    repeat (2) @(negedge clk);
    check(32'({run, slv}), 32'h1);
    check(32'(nvw), 32'h0001);
    wb(1'b0, 8'h00, 32'h0);
    check(rd, 32'h00000001);
    wb(1'b0, 8'hFC, 32'h0);
    check(rd, 32'h0);
    @(posedge clk);
    err <= 1'b1;
    repeat (3) @(negedge clk);
    check(32'(led), 32'h0);
    @(posedge clk);
    err <= 1'b0;
    word <= 16'h0001;
    repeat (2) @(negedge clk);
    check(32'(led), 32'h1);
    power_on(1'b0, 4'h2, 3'h7, 1'b1);
    check(32'({run, slv}), 32'h1);
    check(32'(nvw), 32'h0001);
    @(posedge clk);
    word <= 16'h0000;
    $display("launch control done");
    power_on(1'b1, 4'h5, 3'h7, 1'b1);
    check(32'({cid, run, copen, slv}), 32'h2B);
    power_on(1'b0, 4'h3, 3'h0, 1'b1);
    check(32'({run, slv}), 32'h1);
    power_on(1'b0, 4'h3, 3'h7, 1'b0);
    check(32'({run, slv}), 32'h1);
    power_on(1'b1, 4'h0, 3'h7, 1'b1);
    check(32'({cid, sid, idv}), 32'h001FE);
    wb(1'b1, 8'h08, 32'h00000080);
    repeat (2) @(negedge clk);
    check(32'({idv, lst}), 32'h0);
    wb(1'b1, 8'h08, 32'h00000022);
    wb(1'b0, 8'h04, 32'h0);
    check(rd & 32'h000022FF, 32'h00002022);
    check(32'({nvid, lid}), 32'h2222);
    power_on(1'b1, 4'h0, 3'h7, 1'b1);
    check(32'({cid, idv}), 32'h045);
    $display("canopen and layer setting done");
    final_report();
  end
endmodule : drive_boot_mode_axis_select_test
